// [logic/tci_pkg.sv]
// Constants, types and behaviour list for the three channel interval timer
// Behaviour
// [RL1] Selected, write low, read high: ports 0-2 load counter bytes, port 3 the setup word.
// [RL2] Selected with read low, ports 0-2 drive counter bytes; else bus floats.
// [RL3] Setup word: bits 7:6 channel, 5:4 byte format, 3:1 waveform, 0 decimal.
// [RL4] Channel pick values 0-2 address counters; value 3 is illegal, never sent.
// [RL5] Byte format: 00 latch, 01 low only, 10 high only, 11 low then high.
// [RL6] Waveform field decodes modes 0-5; top bit ignored for modes 2 and 3.
// [RL7] Decimal bit 0 counts 16-bit binary, 1 counts four decimal digits.
// [RL8] Setup word clears the counter to zero; a new count follows in that format.
// [RL9] Two-byte loads come low then high back to back per counter.
// [RL10] Count 0 means 10000H counts; mode 3 count 1 gives 10001H counts.
// [RL11] Mode 0: output low on setup, count after load, high at terminal count.
// [RL12] Mode 0: low gate suspends counting, which resumes when gate returns high.
// [RL13] Mode 0 one-byte: new count halts, restarts with it on the next tick.
// [RL14] Mode 0 two-byte: low byte halts counting, high byte restarts it.
// [RL15] Mode 1: output high on setup; gate rise triggers, output low for count.
// [RL16] Mode 1: runs out regardless of gate; a retrigger reloads the newest count.
// [RL17] Mode 2: output high; start after load with gate high, else on gate rise.
// [RL18] Mode 2: one-tick low pulse every n ticks.
// [RL19] Mode 2: new count takes effect after the current period ends.
// [RL20] Mode 2: low gate forces output high and halts; gate rise restarts.
// [RL21] Mode 3: square wave, high (n+1)/2 and low (n-1)/2 ticks for odd n.
// [RL22] Deselected: bus floats, no transfer, internal state kept.
// [RL23] Latch command freezes a copy of the count for reading without disturbing it.
// [RL24] Channels are independent, each with its own tick, gate and output.
// [RL25] Reads return latched copy if pending, else live; low byte before high.
package tci_pkg;
   localparam logic [1:0] PORT_SETUP = 2'h3;
   localparam int CW_PICK = 6;
   localparam int CW_FMT = 4;
   localparam int CW_WAVE = 1;
   localparam int CW_DEC = 0;
   localparam logic [1:0] FMT_LATCH = 2'h0;
   localparam logic [1:0] FMT_LO = 2'h1;
   localparam logic [1:0] FMT_HI = 2'h2;
   localparam logic [1:0] FMT_BOTH = 2'h3;
   localparam logic [2:0] MODE0 = 3'h0;
   localparam logic [2:0] MODE1 = 3'h1;
   localparam logic [2:0] MODE2 = 3'h2;
   localparam logic [2:0] MODE3 = 3'h3;
   localparam logic [2:0] MODE4 = 3'h4;
   localparam logic [2:0] MODE5 = 3'h5;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_TWO = 16'h0002;
   localparam logic [18:0] PIN_RST = 19'h70000;

   typedef struct packed {
      logic cs_b;
      logic rd_b;
      logic wr_b;
      logic [1:0] port_select;
      logic [7:0] bus_byte;
   } tci_bus_t;

   typedef struct packed {
      tci_bus_t bus;
      logic [2:0] tick;
      logic [2:0] gate;
   } tci_pins_t;

   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] fmt;
      logic dec;
      logic [15:0] cnt;
      logic [15:0] reload;
      logic [7:0] lsb;
      logic wr_hi;
      logic rd_hi;
      logic [15:0] latched;
      logic lat_v;
      logic run;
      logic pend;
      logic trig;
      logic xtra;
      logic out;
   } tci_chan_t;

   typedef struct packed {
      tci_chan_t [2:0] ch;
      logic wr_v;
      logic [1:0] wr_a;
      logic [7:0] wr_dat;
      logic rd_v;
      logic [1:0] rd_a;
      logic [7:0] dout;
      logic [2:0] tick_q;
      logic [2:0] gate_q;
   } tci_state_t;

   localparam tci_state_t ST_RST = '0;
endpackage

// [logic/tci_sync.sv]
// Three stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module tci_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         q <= RST;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Only an agreed level passes, so one-cycle glitches never count
         if (s2_q == s3_q) begin
            q <= s3_q;
         end
      end
   end
endmodule
`default_nettype wire

// [logic/tci_timer.sv]
// Three channel interval timer with strobed byte bus
`timescale 1ns/1ns
`default_nettype none
module tci_timer (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire tci_pkg::tci_bus_t host_bus,
   input wire logic [2:0] count_tick_in,
   input wire logic [2:0] count_enable_in,
   output logic [7:0] bus_byte_out,
   output logic bus_byte_oe,
   output logic [2:0] waveform_out
);
   import tci_pkg::*;

   logic [1:0] rst_sh;
   logic rst_q;
   tci_pins_t pins;
   tci_state_t s_q;
   tci_state_t s_d;
   logic sel;
   logic wr_commit;
   logic rd_done;
   logic [2:0] tick_fall;
   logic [2:0] gate_rise;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sh <= 2'h0;
      end else begin
         rst_sh <= {rst_sh[0], 1'b1};
      end
   end
   assign rst_q = rst_sh[1];

   // Bus strobes, ticks and gates all arrive unsynchronised
   tci_sync #(
      .W($bits(tci_pins_t)),
      .RST(PIN_RST)
   ) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_q),
      .d({host_bus, count_tick_in, count_enable_in}),
      .q(pins)
   );

   function automatic logic [15:0] dec1(input logic [15:0] v, input logic dec);
      logic [15:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (!dec) begin
         r = v - CNT_ONE;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (borrow) begin
               if (r[4*k+:4] == 4'h0) begin
                  r[4*k+:4] = 4'h9;
               end else begin
                  r[4*k+:4] = r[4*k+:4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] rd_byte(input tci_chan_t c);
      logic [15:0] src;
      src = c.lat_v ? c.latched : c.cnt; // RL25
      if (c.fmt == FMT_HI || (c.fmt == FMT_BOTH && c.rd_hi)) begin
         return src[15:8];
      end
      return src[7:0];
   endfunction

   assign sel = !pins.bus.cs_b;
   assign wr_commit = s_q.wr_v && pins.bus.wr_b;
   assign rd_done = s_q.rd_v && pins.bus.rd_b;
   assign tick_fall = s_q.tick_q & ~pins.tick;
   assign gate_rise = ~s_q.gate_q & pins.gate;

   always_comb begin
      tci_chan_t c;
      logic g;
      logic done;
      logic [15:0] val;
      logic [15:0] nx;
      logic [2:0] wm;
      c = '0;
      g = 1'b0;
      done = 1'b0;
      val = '0;
      nx = '0;
      wm = '0;
      s_d = s_q;
      s_d.tick_q = pins.tick;
      s_d.gate_q = pins.gate;

      // A transfer is captured while selected and taken when its strobe ends
      if (sel && !pins.bus.wr_b && pins.bus.rd_b) begin // RL1 RL22
         s_d.wr_v = 1'b1;
         s_d.wr_a = pins.bus.port_select;
         s_d.wr_dat = pins.bus.bus_byte;
      end else if (wr_commit) begin
         s_d.wr_v = 1'b0;
      end
      if (sel && !pins.bus.rd_b && pins.bus.wr_b) begin // RL2
         s_d.rd_v = 1'b1;
         s_d.rd_a = pins.bus.port_select;
      end else if (rd_done) begin
         s_d.rd_v = 1'b0;
      end

      for (int i = 0; i < 3; i++) begin // RL24
         c = s_q.ch[i];
         g = pins.gate[i];

         if (tick_fall[i]) begin
            // Strobe modes hold their low pulse for exactly one tick
            if ((c.mode == MODE4 || c.mode == MODE5) && !c.out) begin
               c.out = 1'b1;
            end
            unique case (c.mode)
               MODE0, MODE4: begin
                  c.trig = 1'b0;
                  if (c.pend) begin
                     c.cnt = c.reload;
                     c.pend = 1'b0;
                     c.run = 1'b1;
                  end else if (c.run && g) begin // RL12
                     nx = dec1(c.cnt, c.dec); // RL7
                     c.cnt = nx;
                     if (nx == 16'h0000) begin
                        if (c.mode == MODE0) begin
                           c.out = 1'b1; // RL11
                        end else begin
                           c.out = 1'b0;
                           c.run = 1'b0;
                        end
                     end
                  end
               end
               MODE1, MODE5: begin
                  if (c.trig && c.pend) begin // RL15 RL16
                     c.trig = 1'b0;
                     c.cnt = c.reload;
                     c.run = 1'b1;
                     if (c.mode == MODE1) begin
                        c.out = 1'b0;
                     end
                  end else if (c.run) begin
                     nx = dec1(c.cnt, c.dec);
                     c.cnt = nx;
                     if (nx == 16'h0000) begin // RL10
                        c.run = 1'b0;
                        c.out = (c.mode == MODE1);
                     end
                  end
                  c.trig = 1'b0;
               end
               MODE2: begin
                  if (!g) begin
                     c.out = 1'b1;
                  end else if (c.trig || c.pend) begin // RL17
                     c.cnt = c.reload;
                     c.trig = 1'b0;
                     c.pend = 1'b0;
                     c.run = 1'b1;
                     c.out = 1'b1;
                  end else if (c.run) begin
                     if (c.cnt == CNT_ONE) begin
                        c.cnt = c.reload; // RL19
                        c.out = 1'b1;
                     end else begin
                        nx = dec1(c.cnt, c.dec);
                        c.cnt = nx;
                        c.out = (nx != CNT_ONE); // RL18
                     end
                  end
               end
               MODE3: begin
                  if (!g) begin
                     c.out = 1'b1;
                  end else if (c.trig || c.pend) begin
                     c.cnt = {c.reload[15:1], 1'b0};
                     c.xtra = c.reload[0];
                     c.trig = 1'b0;
                     c.pend = 1'b0;
                     c.run = 1'b1;
                     c.out = 1'b1;
                  end else if (c.run) begin
                     nx = dec1(dec1(c.cnt, c.dec), c.dec);
                     c.cnt = nx;
                     if (nx == 16'h0000) begin
                        // Odd counts stretch the high half by one tick
                        if (c.xtra) begin // RL21
                           c.xtra = 1'b0;
                           c.cnt = CNT_TWO;
                        end else begin
                           c.out = !c.out;
                           c.cnt = {c.reload[15:1], 1'b0};
                           c.xtra = c.reload[0] && c.out; // RL10
                        end
                     end
                  end
               end
               default: c.trig = 1'b0;
            endcase
         end

         // Low gate in modes 2 and 3 acts at once, not at the next tick
         if ((c.mode == MODE2 || c.mode == MODE3) && !g) begin // RL20
            c.out = 1'b1;
         end

         // Set after consume so a gate edge in the same cycle survives
         if (gate_rise[i] && c.mode != MODE0 && c.mode != MODE4) begin
            c.trig = 1'b1;
         end

         done = 1'b0;
         val = c.reload;
         if (wr_commit && s_q.wr_a == 2'(i)) begin
            unique case (c.fmt)
               FMT_LO: begin
                  val = {8'h00, s_q.wr_dat};
                  done = 1'b1;
               end
               FMT_HI: begin
                  val = {s_q.wr_dat, 8'h00};
                  done = 1'b1;
               end
               FMT_BOTH: begin // RL9
                  if (!c.wr_hi) begin
                     c.lsb = s_q.wr_dat;
                     c.wr_hi = 1'b1;
                     if (c.mode == MODE0) begin
                        c.run = 1'b0; // RL14
                     end
                  end else begin
                     val = {s_q.wr_dat, c.lsb};
                     c.wr_hi = 1'b0;
                     done = 1'b1;
                  end
               end
               FMT_LATCH: done = 1'b0;
            endcase
         end
         if (done) begin
            c.reload = val;
            unique case (c.mode)
               MODE0, MODE4: begin // RL13
                  c.pend = 1'b1;
                  c.run = 1'b0;
                  if (c.mode == MODE0) begin
                     c.out = 1'b0;
                  end
               end
               MODE1, MODE5: begin
                  c.pend = 1'b1;
               end
               MODE2, MODE3: begin
                  if (!c.run) begin
                     c.pend = 1'b1;
                  end
               end
               default: c.pend = 1'b0;
            endcase
         end

         // Read end first, so a latch or setup word in the same cycle wins
         if (rd_done && s_q.rd_a == 2'(i)) begin // RL25
            if (c.fmt == FMT_BOTH && !c.rd_hi) begin
               c.rd_hi = 1'b1;
            end else begin
               c.rd_hi = 1'b0;
               c.lat_v = 1'b0;
            end
         end

         // Pick value 3 matches no channel and is dropped
         if (wr_commit && s_q.wr_a == PORT_SETUP && s_q.wr_dat[CW_PICK+:2] == 2'(i)) begin // RL4
            if (s_q.wr_dat[CW_FMT+:2] == FMT_LATCH) begin // RL5
               if (!c.lat_v) begin // RL23
                  c.latched = c.cnt;
                  c.lat_v = 1'b1;
                  c.rd_hi = 1'b0;
               end
            end else begin // RL3
               wm = s_q.wr_dat[CW_WAVE+:3];
               if (wm[1]) begin // RL6
                  wm[2] = 1'b0;
               end
               c.mode = wm;
               c.fmt = s_q.wr_dat[CW_FMT+:2];
               c.dec = s_q.wr_dat[CW_DEC];
               c.cnt = 16'h0000; // RL8
               c.run = 1'b0;
               c.pend = 1'b0;
               c.trig = 1'b0;
               c.xtra = 1'b0;
               c.wr_hi = 1'b0;
               c.rd_hi = 1'b0;
               c.lat_v = 1'b0;
               c.out = (wm != MODE0); // RL11 RL15 RL17 RL21
            end
         end

         s_d.ch[i] = c;
      end

      s_d.dout = 8'h00;
      if (pins.bus.port_select != PORT_SETUP) begin
         s_d.dout = rd_byte(s_q.ch[pins.bus.port_select]);
      end
   end

   always_ff @(posedge core_clk or negedge rst_q) begin
      if (!rst_q) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus_byte_out = s_q.dout;
   assign bus_byte_oe = sel && !pins.bus.rd_b && pins.bus.wr_b &&
      pins.bus.port_select != PORT_SETUP; // RL2 RL22
   assign waveform_out = {s_q.ch[2].out, s_q.ch[1].out, s_q.ch[0].out};

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_q);

   AST_FLOAT_DESEL: assert property (pins.bus.cs_b |-> !bus_byte_oe) // RL22
      else $error("bus driven while deselected");
   AST_FLOAT_SETUP: assert property (pins.bus.port_select == PORT_SETUP |-> !bus_byte_oe) // RL2
      else $error("bus driven on setup port");
   AST_SETUP_CLEAR: assert property (wr_commit && s_q.wr_a == PORT_SETUP && // RL8
      s_q.wr_dat[7:6] == 2'h0 && s_q.wr_dat[5:4] != FMT_LATCH
      |=> s_q.ch[0].cnt == 16'h0000 && !s_q.ch[0].run)
      else $error("setup word did not clear counter");
   AST_MODE_OUT: assert property (wr_commit && s_q.wr_a == PORT_SETUP && // RL11
      s_q.wr_dat[7:6] == 2'h1 && s_q.wr_dat[5:4] != FMT_LATCH
      |=> waveform_out[1] == ($past(s_q.wr_dat[3:1]) != MODE0))
      else $error("output level after setup wrong");
   AST_BAD_PICK: assert property (wr_commit && s_q.wr_a == PORT_SETUP && // RL4
      s_q.wr_dat[7:6] == 2'h3 |=> $stable(s_q.ch[0].mode) && $stable(s_q.ch[1].mode)
      && $stable(s_q.ch[2].mode))
      else $error("illegal pick changed a channel");
   AST_LATCH_FROZEN: assert property (s_q.ch[0].lat_v && $past(s_q.ch[0].lat_v) // RL23
      |-> $stable(s_q.ch[0].latched))
      else $error("latched copy moved");
   AST_GATE_HALT_M0: assert property (s_q.ch[0].mode == MODE0 && !pins.gate[0] && // RL12
      !s_q.ch[0].pend && !wr_commit && !(s_q.wr_v) |=> $stable(s_q.ch[0].cnt))
      else $error("mode 0 counted with gate low");
   AST_GATE_LOW_HIGH: assert property ((s_q.ch[1].mode == MODE2 || // RL20
      s_q.ch[1].mode == MODE3) && !pins.gate[1] && !wr_commit |=> waveform_out[1])
      else $error("gate low did not force output high");
   AST_M2_PULSE_ONE: assert property (s_q.ch[1].mode == MODE2 && !waveform_out[1] && // RL18
      tick_fall[1] && !wr_commit |=> waveform_out[1])
      else $error("mode 2 pulse longer than one tick");
   AST_M0_TC: assert property (s_q.ch[0].mode == MODE0 && $rose(waveform_out[0]) // RL11
      |-> s_q.ch[0].cnt == 16'h0000)
      else $error("mode 0 output rose before terminal count");
   AST_M1_RUN: assert property (s_q.ch[1].mode == MODE1 && s_q.ch[1].run && // RL16
      !tick_fall[1] && !wr_commit |=> $stable(waveform_out[1]))
      else $error("mode 1 output moved between ticks");
endmodule
`default_nettype wire

// [sim/tci_host_model.sv]
// Host bus model that drives the strobed byte bus of the timer
`timescale 1ns/1ns
`default_nettype none
module tci_host_model (
   input wire logic core_clk,
   input wire logic [7:0] bus_byte_out,
   input wire logic bus_byte_oe,
   output var tci_pkg::tci_bus_t host_bus
);
   import tci_pkg::*;

   initial begin
      host_bus = '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00};
   end

   // Strobe held 8 cycles low and 8 high, above the 4 the synchroniser needs
   task automatic wr(input logic sel_b, input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      host_bus.cs_b <= sel_b;
      host_bus.wr_b <= 1'b0;
      host_bus.port_select <= a;
      host_bus.bus_byte <= d;
      repeat (8) @(posedge core_clk);
      host_bus.wr_b <= 1'b1;
      host_bus.cs_b <= 1'b1;
      repeat (8) @(posedge core_clk);
      // Released data shows the inverse, never a stale copy
      host_bus.bus_byte <= ~d;
   endtask

   task automatic wr16(input logic [1:0] a, input logic [15:0] v);
      wr(1'b0, a, v[7:0]);
      wr(1'b0, a, v[15:8]);
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic oe);
      int n;
      @(posedge core_clk);
      host_bus.cs_b <= 1'b0;
      host_bus.rd_b <= 1'b0;
      host_bus.port_select <= a;
      n = 0;
      while (bus_byte_oe !== 1'b1 && n < 12) begin
         @(posedge core_clk);
         n++;
      end
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      d = bus_byte_out;
      oe = bus_byte_oe;
      @(posedge core_clk);
      host_bus.rd_b <= 1'b1;
      host_bus.cs_b <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// [sim/test_three_channel_interval_timer.sv]
// Self-checking bench for the three channel interval timer
`timescale 1ns/1ns
`default_nettype none
module test_three_channel_interval_timer;
   import tci_pkg::*;
   logic core_clk;
   logic rst_b;
   logic [2:0] tick;
   logic [2:0] gate;
   logic [7:0] dout;
   logic oe;
   logic [2:0] wave;
   tci_bus_t hb;
   logic [7:0] rv;
   logic rv_oe;
   logic w [16];
   logic [31:0] ex;
   int fail_count;
   int num_checks;
   int lo_run;
   int hi_run;
   int f;

   tci_host_model h (.core_clk(core_clk), .bus_byte_out(dout), .bus_byte_oe(oe),
      .host_bus(hb));
   tci_timer dut (.core_clk(core_clk), .rst_b(rst_b), .host_bus(hb), .count_tick_in(tick),
      .count_enable_in(gate), .bus_byte_out(dout), .bus_byte_oe(oe), .waveform_out(wave));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Channel pick is never 3
   function automatic logic [7:0] cw(input logic [1:0] pick, input logic [1:0] fmt,
      input logic [2:0] mode, input logic dec);
      return {pick, fmt, mode, dec};
   endfunction

   // Ticks count on the falling edge; idle level is high
   task automatic pulse(input logic [2:0] m);
      @(posedge core_clk);
      tick <= ~m;
      repeat (8) @(posedge core_clk);
      tick <= 3'h7;
      repeat (8) @(posedge core_clk);
   endtask

   task automatic set_gate(input int c, input logic v);
      @(posedge core_clk);
      gate[c] <= v;
      repeat (8) @(posedge core_clk);
   endtask

   // Whole run is near 1200 cycles; a hang far past that is cut off
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      results();
   end

   initial begin
      tick = 3'h7;
      gate = 3'h7;
      rst_b = 1'b0;
      fail_count = 0;
      num_checks = 0;
      ex = 32'h33123112;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge core_clk);
      check(wave, 3'h0);
      check(oe, 1'b0);
      // Mode 0 with a gate pause in mid count
      h.wr(1'b0, PORT_SETUP, cw(2'h0, FMT_LO, MODE0, 1'b0));
      check(wave[0], 1'b0);
      h.wr(1'b0, 2'h0, 8'h03);
      pulse(3'h1);
      pulse(3'h1);
      set_gate(0, 1'b0);
      pulse(3'h1);
      pulse(3'h1);
      check(wave[0], 1'b0);
      set_gate(0, 1'b1);
      pulse(3'h1);
      check(wave[0], 1'b0);
      pulse(3'h1);
      check(wave[0], 1'b1);
      // Mode 0 rewrite while the count runs on past zero
      h.wr(1'b0, 2'h0, 8'h02);
      pulse(3'h1);
      pulse(3'h1);
      check(wave[0], 1'b0);
      pulse(3'h1);
      check(wave[0], 1'b1);
      // Mode 2 through the x10 encoding
      h.wr(1'b0, PORT_SETUP, cw(2'h1, FMT_LO, 3'h6, 1'b0));
      check(wave[1], 1'b1);
      h.wr(1'b0, 2'h1, 8'h03);
      for (int i = 0; i < 6; i++) begin
         pulse(3'h2);
         check(wave[1], (i % 3 == 2) ? 1'b0 : 1'b1);
      end
      // New count waits for the running period to end
      h.wr(1'b0, 2'h1, 8'h02);
      pulse(3'h2);
      check(wave[1], 1'b1);
      pulse(3'h2);
      check(wave[1], 1'b0);
      set_gate(1, 1'b0);
      check(wave[1], 1'b1);
      set_gate(1, 1'b1);
      // Mode 1 one-shot, gate dropped mid pulse
      h.wr(1'b0, PORT_SETUP, cw(2'h1, FMT_LO, MODE1, 1'b0));
      check(wave[1], 1'b1);
      h.wr(1'b0, 2'h1, 8'h02);
      pulse(3'h2);
      check(wave[1], 1'b1);
      set_gate(1, 1'b0);
      set_gate(1, 1'b1);
      pulse(3'h2);
      check(wave[1], 1'b0);
      set_gate(1, 1'b0);
      pulse(3'h2);
      check(wave[1], 1'b0);
      pulse(3'h2);
      check(wave[1], 1'b1);
      // Mode 3 with odd count 5
      h.wr(1'b0, PORT_SETUP, cw(2'h2, FMT_LO, MODE3, 1'b0));
      h.wr(1'b0, 2'h2, 8'h05);
      for (int i = 0; i < 16; i++) begin
         pulse(3'h4);
         w[i] = wave[2];
      end
      f = 1;
      while (f < 12 && !(w[f-1] === 1'b1 && w[f] === 1'b0)) f++;
      lo_run = 0;
      while (f < 16 && w[f] === 1'b0) begin
         lo_run++;
         f++;
      end
      hi_run = 0;
      while (f < 16 && w[f] === 1'b1) begin
         hi_run++;
         f++;
      end
      check(lo_run[15:0], 16'h0002);
      check(hi_run[15:0], 16'h0003);
      // Decimal count steps 10 down to 09
      h.wr(1'b0, PORT_SETUP, cw(2'h2, FMT_LO, MODE2, 1'b1));
      h.wr(1'b0, 2'h2, 8'h10);
      pulse(3'h4);
      pulse(3'h4);
      h.rd(2'h2, rv, rv_oe);
      check(rv, 8'h09);
      // Latched read while the count keeps running
      h.wr(1'b0, PORT_SETUP, cw(2'h0, FMT_BOTH, MODE2, 1'b0));
      check(wave[0], 1'b1);
      h.wr16(2'h0, 16'h1234);
      pulse(3'h1);
      pulse(3'h1);
      h.wr(1'b0, PORT_SETUP, cw(2'h0, FMT_LATCH, MODE0, 1'b0));
      pulse(3'h1);
      pulse(3'h1);
      h.wr(1'b1, PORT_SETUP, cw(2'h0, FMT_LO, MODE0, 1'b0));
      check(wave[0], 1'b1);
      for (int i = 0; i < 4; i++) begin
         h.rd(2'h0, rv, rv_oe);
         check(rv_oe, 1'b1);
         check(rv, ex[8*(3-i) +: 8]);
      end
      h.rd(PORT_SETUP, rv, rv_oe);
      check(rv_oe, 1'b0);
      results();
   end
endmodule
`default_nettype wire
